// [rtl/ptr_map.vh]
`ifndef PTR_MAP_VH
`define PTR_MAP_VH
// ==========================================================================
// Command codes
`define PTR_CMD_PIN 8'h97
`define PTR_CMD_IOUT 8'h8c
`define PTR_CMD_EIN 8'h86
// ==========================================================================
// Direct-format coefficients for the energy readout
`define PTR_COEF_M 8'h01
`define PTR_COEF_R 8'h00
`define PTR_COEF_B 8'h00
// ==========================================================================
// Accumulator limits
`define PTR_ACC_MAX 15'h7fff
`define PTR_ROLL_MAX 8'hff
// ==========================================================================
// Timing
`define PTR_CLK_HZ 100000000
`define PTR_AC_CYCLES 3'h4
`define PTR_AVG_SEC 2
`define PTR_AVG_MAX_SEC 10
`define PTR_AVG_SAMPLES 6'h20
`define PTR_AVG_SHIFT 5
`define PTR_FILT_SHIFT 4
`define PTR_EIN_MAX_MS 100
// ==========================================================================
// Word and block read framing
`define PTR_EIN_LEN 8'h04
`define PTR_WORD_LEN 8'h02
`endif

// [rtl/ptr_avg.v]
`include "ptr_map.vh"
// ==========================================================================
// Smoothing stage: boxcar mean over a window, or a first-order filter
module ptr_avg (
	input wire clk,
	input wire reset_n,
	input wire filt_mode,
	input wire smp_en,
	input wire [15:0] smp,
	output reg [15:0] avg_q
);
	reg [21:0] sum_q;
	reg [5:0] cnt_q;
	reg [19:0] filt_q;
	wire [21:0] sum_n;
	wire [19:0] filt_n;

	assign sum_n = sum_q + {6'h00, smp};
	// Shift filter: y += (x - y) / 16, roughly 0.13 Hz at 12.5 Hz sampling, 0.15 Hz at 15 Hz
	assign filt_n = filt_q + ({4'h0, smp} >> `PTR_FILT_SHIFT) - (filt_q >> `PTR_FILT_SHIFT);

	// Only finished results reach avg_q, never the running sum
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sum_q <= 22'h000000;
			cnt_q <= 6'h00;
			filt_q <= 20'h00000;
			avg_q <= 16'h0000;
		end else if (smp_en) begin
			filt_q <= filt_n;
			if (filt_mode) begin
				avg_q <= filt_n[15:0];
			end
			if (cnt_q == `PTR_AVG_SAMPLES - 6'h01) begin
				cnt_q <= 6'h00;
				sum_q <= 22'h000000;
				if (!filt_mode) begin
					avg_q <= sum_n[`PTR_AVG_SHIFT +: 16];
				end
			end else begin
				cnt_q <= cnt_q + 6'h01;
				sum_q <= sum_n;
			end
		end
	end
endmodule

// [rtl/ptr_top.v]
`include "ptr_map.vh"
// Summary of operation
// - Input power command 97h returns watts in linear format.
// - Input power is averaged over a fixed 32 samples, about 2.1 to 2.6 s, or filtered.
// - Filter bandwidth lies between 0.1 Hz and 0.5 Hz.
// - Output current command 8Ch returns amperes in linear format.
// - Output current averaged over a fixed 32 samples, about 2.1 to 2.6 s, or filtered.
// - Energy command 86h returns power sum plus sample count.
// - Energy sum uses direct format, m=01h, R=00h, b=00h.
// - Each sample is input power averaged over 4 AC cycles.
// - Accumulator and count update every 80 or 66.7 ms.
// - Energy readings refresh faster than every 100 ms.
// - Power accumulator wraps past 15-bit maximum 7FFFh.
// - One-byte wrap counter rolls from FFh to 00h.
// - Sum, wrap count and sample count latch together.
// - Energy readout uses block read with packet error checking.
module ptr_top (
	input wire clk,
	input wire reset_n,
	input wire ac_cycle,
	input wire pin_valid,
	input wire [15:0] pin_raw,
	input wire iout_valid,
	input wire [15:0] iout_raw,
	input wire filt_mode,
	input wire [4:0] pin_exp,
	input wire [4:0] iout_exp,
	input wire cmd_valid,
	input wire [7:0] cmd_code,
	input wire byte_ack,
	output wire rsp_valid,
	output reg [7:0] rsp_byte_q,
	output reg rsp_last_q,
	output reg rsp_busy_q,
	output reg cmd_err_q,
	output reg ein_tick_q
);
	// ======================================================================
	// Helpers
	// Linear format: 5-bit exponent above an 11-bit mantissa
	// Limitation: readings wider than 11 bits lose their top bits, so the
	// exponent given with each channel must match its raw scaling
	function [15:0] lin_enc;
		input [15:0] val;
		input [4:0] ex;
		begin
			lin_enc = {ex, val[10:0]};
		end
	endfunction

	// SMBus PEC is CRC-8, polynomial x^8+x^2+x+1
	// Bit-serial loop; unrolls to a short XOR tree per byte
	function [7:0] crc8;
		input [7:0] crc;
		input [7:0] dat;
		reg [7:0] c;
		integer i;
		begin
			c = crc ^ dat;
			for (i = 0; i < 8; i = i + 1) begin
				c = c[7] ? ((c << 1) ^ 8'h07) : (c << 1);
			end
			crc8 = c;
		end
	endfunction

	// ======================================================================
	// Sample period: average instantaneous power over 4 AC cycles
	reg [2:0] ac_cnt_q;
	reg [31:0] win_sum_q;
	reg [15:0] win_n_q;
	reg [15:0] psample_q;
	reg smp_en_q;
	wire win_done;
	wire [31:0] win_mean;
	assign win_done = ac_cycle && (ac_cnt_q == `PTR_AC_CYCLES - 3'h1);
	// Empty window gives 0 W; the mux hides the divide by zero
	// A mean of 16-bit samples always fits 16 bits, so the top half is zero
	assign win_mean = (win_n_q == 16'h0000) ? 32'h00000000 :
		win_sum_q / {16'h0000, win_n_q};

	// Window closes on every fourth AC cycle, 80 ms at 50 Hz
	// A strobe in the closing cycle already belongs to the next window
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ac_cnt_q <= 3'h0;
			win_sum_q <= 32'h00000000;
			win_n_q <= 16'h0000;
			psample_q <= 16'h0000;
			smp_en_q <= 1'b0;
		end else begin
			smp_en_q <= win_done;
			if (win_done) begin
				ac_cnt_q <= 3'h0;
				win_sum_q <= pin_valid ? {16'h0000, pin_raw} : 32'h00000000;
				win_n_q <= pin_valid ? 16'h0001 : 16'h0000;
				// Mean of the window; no samples means 0 W added
				psample_q <= win_mean[15:0];
			end else begin
				if (ac_cycle) begin
					ac_cnt_q <= ac_cnt_q + 3'h1;
				end
				if (pin_valid) begin
					win_sum_q <= win_sum_q + {16'h0000, pin_raw};
					win_n_q <= win_n_q + 16'h0001;
				end
			end
		end
	end

	// ======================================================================
	// Energy accumulator with wrap and sample counters
	reg [14:0] acc_q;
	reg [7:0] roll_q;
	reg [7:0] nsmp_q;
	reg [14:0] ein_acc_q;
	reg [7:0] ein_roll_q;
	reg [7:0] ein_n_q;
	wire [15:0] acc_sum;
	wire [7:0] roll_n;
	wire [7:0] nsmp_n;
	assign acc_sum = {1'b0, acc_q} + {1'b0, psample_q[14:0]};
	// Carry out of bit 14 means the sum passed the maximum
	assign roll_n = acc_sum[15] ? roll_q + 8'h01 : roll_q;
	assign nsmp_n = nsmp_q + 8'h01;
	// Live and snapshot counters share one next value, so they cannot drift
	// Limitation: a host slower than one wrap period loses whole wraps

	// Accumulate once per sample pulse; the pulse is one cycle long
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			acc_q <= 15'h0000;
			roll_q <= 8'h00;
			nsmp_q <= 8'h00;
			ein_acc_q <= 15'h0000;
			ein_roll_q <= 8'h00;
			ein_n_q <= 8'h00;
			ein_tick_q <= 1'b0;
		end else begin
			ein_tick_q <= smp_en_q;
			if (smp_en_q) begin
				acc_q <= acc_sum[14:0];
				roll_q <= roll_n;
				nsmp_q <= nsmp_n;
				// One snapshot so count always matches sum
				ein_acc_q <= acc_sum[14:0];
				ein_roll_q <= roll_n;
				ein_n_q <= nsmp_n;
			end
		end
	end

	// ======================================================================
	// Smoothed power and current readings
	// 32 samples at line pacing span about 2.6 s at 50 Hz, 2.1 s at 60 Hz
	// The filter state runs in both modes, so a mode change needs no warm-up
	wire [15:0] pin_avg;
	wire [15:0] iout_avg;
	reg iout_en_q;

	ptr_avg u_pin_avg (
		.clk(clk),
		.reset_n(reset_n),
		.filt_mode(filt_mode),
		.smp_en(smp_en_q),
		.smp(psample_q),
		.avg_q(pin_avg)
	);

	// Current is sampled on the same 4-cycle pacing as power
	// Only the newest current strobe counts; the averager does the smoothing
	reg [15:0] iout_smp_q;
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			iout_smp_q <= 16'h0000;
			iout_en_q <= 1'b0;
		end else begin
			iout_en_q <= win_done;
			if (iout_valid) begin
				iout_smp_q <= iout_raw;
			end
		end
	end

	ptr_avg u_iout_avg (
		.clk(clk),
		.reset_n(reset_n),
		.filt_mode(filt_mode),
		.smp_en(iout_en_q),
		.smp(iout_smp_q),
		.avg_q(iout_avg)
	);

	// ======================================================================
	// Response builder: word and block read bytes, block count first, PEC last
	reg [39:0] frame_q;
	reg [2:0] idx_q;
	reg [2:0] nbytes_q;
	reg [7:0] pec_q;
	reg [39:0] load_frame;
	reg [2:0] load_n;
	reg load_ok;
	wire [15:0] pin_word;
	wire [15:0] iout_word;
	wire [7:0] frame_byte;
	assign rsp_valid = rsp_busy_q;
	assign pin_word = lin_enc(pin_avg, pin_exp);
	assign iout_word = lin_enc(iout_avg, iout_exp);
	// Later bytes come from the latched frame, never from live values
	assign frame_byte = frame_q[8 * idx_q +: 8];

	// Frame that a taken command loads, low byte first, PEC added later
	// Word readings carry two data bytes, the energy block a count byte and four data bytes
	always @* begin
		load_frame = 40'h0000000000;
		load_n = 3'h0;
		load_ok = 1'b1;
		case (cmd_code)
		`PTR_CMD_PIN: begin
			load_frame = {24'h000000, pin_word};
			load_n = 3'h2;
		end
		`PTR_CMD_IOUT: begin
			load_frame = {24'h000000, iout_word};
			load_n = 3'h2;
		end
		`PTR_CMD_EIN: begin
			// m=1, b=0, R=0: raw sum is the direct-format value
			load_frame = {ein_n_q, ein_roll_q, 1'b0, ein_acc_q, `PTR_EIN_LEN};
			load_n = 3'h5;
		end
		default: begin
			load_ok = 1'b0;
		end
		endcase
	end

	// New commands are refused while a frame is still being sent
	// Dropped, not queued: the host waits for the PEC byte anyway
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			frame_q <= 40'h0000000000;
			idx_q <= 3'h0;
			nbytes_q <= 3'h0;
			pec_q <= 8'h00;
			rsp_byte_q <= 8'h00;
			rsp_last_q <= 1'b0;
			rsp_busy_q <= 1'b0;
			cmd_err_q <= 1'b0;
		end else begin
			if (!rsp_busy_q && cmd_valid) begin
				// Unknown codes leave the bus idle and raise the flag
				cmd_err_q <= !load_ok;
				rsp_busy_q <= load_ok;
				idx_q <= 3'h1;
				rsp_last_q <= 1'b0;
				pec_q <= 8'h00;
				frame_q <= load_frame;
				nbytes_q <= load_n;
				rsp_byte_q <= load_frame[7:0];
			end else if (rsp_busy_q && byte_ack) begin
				// Running CRC over bytes already delivered
				pec_q <= crc8(pec_q, rsp_byte_q);
				if (rsp_last_q) begin
					rsp_busy_q <= 1'b0;
					rsp_last_q <= 1'b0;
				end else if (idx_q == nbytes_q) begin
					rsp_byte_q <= crc8(pec_q, rsp_byte_q);
					rsp_last_q <= 1'b1;
				end else begin
					rsp_byte_q <= frame_byte;
					idx_q <= idx_q + 3'h1;
				end
			end
		end
	end
endmodule

// [tb/ptr_top_properties.sv]
`include "ptr_map.vh"
// ======
// Port checks for the readout
module ptr_top_properties (
	input wire clk,
	input wire reset_n,
	input wire ac_cycle,
	input wire cmd_valid,
	input wire [7:0] cmd_code,
	input wire byte_ack,
	input wire [7:0] rsp_byte_q,
	input wire rsp_last_q,
	input wire rsp_busy_q,
	input wire cmd_err_q,
	input wire ein_tick_q,
	input wire rsp_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	// Decode, and a line-cycle count that mirrors window closing
	wire take = cmd_valid && !rsp_busy_q;
	wire known = cmd_code == `PTR_CMD_PIN || cmd_code == `PTR_CMD_IOUT || cmd_code == `PTR_CMD_EIN;
	logic [1:0] ac_q;
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			ac_q <= 2'h0;
		else if (ac_cycle)
			ac_q <= ac_q + 2'h1;
	end
	known_start_a:
	assert property (take && known |=> rsp_busy_q && !cmd_err_q) else $error("no frame");
	unknown_err_a:
	assert property (take && !known |=> cmd_err_q && !rsp_busy_q) else $error("no error");
	ein_count_a:
	assert property (take && cmd_code == `PTR_CMD_EIN |=> rsp_byte_q == 8'h04) else $error("count");
	byte_hold_a:
	assert property (rsp_busy_q && !byte_ack |=> $stable(rsp_byte_q) && rsp_busy_q) else $error("hold");
	last_end_a:
	assert property (rsp_last_q && byte_ack |=> !rsp_busy_q) else $error("frame end");
	last_busy_a:
	assert property (rsp_last_q |-> rsp_busy_q) else $error("stray last");
	valid_end_a:
	assert property (rsp_last_q && byte_ack |=> !rsp_valid) else $error("valid after frame");
	tick_pulse_a:
	assert property (ein_tick_q |=> !ein_tick_q) else $error("tick width");
	tick_due_a:
	assert property (ac_cycle && ac_q == 2'h3 |-> ##2 ein_tick_q) else $error("tick late");
	tick_cause_a:
	assert property (ein_tick_q |-> $past(ac_cycle, 2) && $past(ac_q, 2) == 2'h3) else $error("tick");
	cover property (take && cmd_code == `PTR_CMD_EIN);
	cover property (rsp_last_q && byte_ack);
	cover property (cmd_err_q);
endmodule

// [tb/ptr_host.sv]
// ======
// Polling controller: one read frame per call
module ptr_host (
	input wire clk,
	input wire [7:0] rsp_byte_q,
	input wire rsp_last_q,
	output logic cmd_valid = 0,
	output logic [7:0] cmd_code = 0,
	output logic byte_ack = 0
);
	timeunit 1ns;
	timeprecision 1ps;
	// Caller spaces the polls, scaled from the host range
	// Stall bits slow acks; junk requests meanwhile must be ignored
	task automatic poll(input [7:0] code, input int n, input [7:0] stl,
			output logic [7:0] b [6], output logic [5:0] l);
		@(negedge clk);
		cmd_valid = 1;
		cmd_code = code;
		for (int i = 0; i < n; i++) begin
			@(negedge clk);
			byte_ack = !stl[i];
			cmd_valid = stl[i];
			cmd_code = ~code;
			if (stl[i]) begin
				@(negedge clk);
				cmd_valid = 0;
				byte_ack = 1;
			end
			// Byte stands until the ack edge, so it is read just before it
			b[i] = rsp_byte_q;
			l[i] = rsp_last_q;
		end
		@(negedge clk);
		byte_ack = 0;
		cmd_valid = 0;
	endtask
endmodule

// [tb/ptr_top_test.sv]
`include "ptr_map.vh"
// ======
// Bench with a behavioural energy model
module ptr_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, reset_n = 0, ac_cycle = 0, pin_valid = 0, iout_valid = 0, filt_mode = 0;
	logic [15:0] pin_raw = 0, iout_raw = 0;
	logic [4:0] pin_exp = 0, iout_exp = 0;
	wire cmd_valid, byte_ack, rsp_valid, rsp_last_q, rsp_busy_q, cmd_err_q, ein_tick_q;
	wire [7:0] cmd_code, rsp_byte_q;
	int failures = 0, total_checks = 0;
	logic [31:0] rng = 32'd91421;
	logic [31:0] r = 0;
	logic [14:0] acc = 0;
	logic [7:0] roll = 0, cnt = 0, bb [6];
	logic [5:0] ll;
	always #5 clk = ~clk;
	ptr_top i_dut (.clk(clk), .reset_n(reset_n), .ac_cycle(ac_cycle), .pin_valid(pin_valid),
		.pin_raw(pin_raw), .iout_valid(iout_valid), .iout_raw(iout_raw), .filt_mode(filt_mode),
		.pin_exp(pin_exp), .iout_exp(iout_exp), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
		.byte_ack(byte_ack), .rsp_valid(rsp_valid), .rsp_byte_q(rsp_byte_q),
		.rsp_last_q(rsp_last_q), .rsp_busy_q(rsp_busy_q), .cmd_err_q(cmd_err_q),
		.ein_tick_q(ein_tick_q));
	ptr_host i_host (.clk(clk), .rsp_byte_q(rsp_byte_q), .rsp_last_q(rsp_last_q),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code), .byte_ack(byte_ack));
	// CRC-8, polynomial 07h, one byte at a time
	function automatic [7:0] crc(input [7:0] c, input [7:0] d);
		c = c ^ d;
		for (int i = 0; i < 8; i++) c = c[7] ? (c << 1) ^ 8'h07 : c << 1;
		return c;
	endfunction
	function automatic [31:0] xs(input [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic chk(input string n, input [7:0] e, input [7:0] g);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	// Whole frame against the model, PEC worked out here
	task automatic rd(input [7:0] code, input int n, input logic [7:0] e [6]);
		logic [7:0] c;
		c = 0;
		for (int i = 0; i < n - 1; i++) c = crc(c, e[i]);
		e[n - 1] = c;
		rng = xs(rng);
		i_host.poll(code, n, rng[7:0], bb, ll);
		chk("rsp_valid", 0, rsp_valid);
		for (int i = 0; i < n; i++) begin
			chk("rsp_byte", e[i], bb[i]);
			chk("rsp_last", i == n - 1, ll[i]);
		end
	endtask
	task automatic ein();
		rd(`PTR_CMD_EIN, 6, '{8'h04, acc[7:0], {1'b0, acc[14:8]}, roll, cnt, 8'h00});
	endtask
	// One window of four line cycles; k strobes of p, none means zero
	task automatic win(input int k, input [15:0] p, input [15:0] c, input bit mid);
		// Each strobe leads its line pulse, so the fourth pulse closes on all k
		for (int j = 0; j < 4; j++) begin
			@(negedge clk);
			pin_valid = j < k;
			iout_valid = 1;
			pin_raw = p;
			iout_raw = c;
			@(negedge clk);
			pin_valid = 0;
			iout_valid = 0;
			pin_raw = ~p;
			iout_raw = ~c;
			ac_cycle = 1;
			@(negedge clk);
			ac_cycle = 0;
			if (mid && j == 1) ein();
		end
		repeat (3) @(negedge clk);
		if (k > 0 && acc + p[14:0] > 16'h7fff) roll++;
		acc = acc + (k > 0 ? p[14:0] : 15'h0);
		cnt++;
	endtask
	task final_report();
		if (failures == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Main sequence; wraps of both counters need some 455 windows
	initial begin
		repeat (16) @(negedge clk);
		reset_n = 1;
		i_host.poll(8'h5a, 0, 8'h00, bb, ll);
		chk("cmd_err", 1, cmd_err_q);
		ein();
		chk("cmd_err", 0, cmd_err_q);
		for (int i = 0; i < 700; i++) begin
			rng = xs(rng);
			filt_mode = rng[20];
			win(rng[31:29] % 5, {1'b0, rng[14:0] | 15'h4000}, rng[15:0], i % 8 == 0);
			ein();
		end
		filt_mode = 0;
		rng = xs(rng);
		r = rng;
		pin_exp = r[4:0];
		iout_exp = r[9:5];
		repeat (64) win(4, {5'h0, r[20:10]}, {5'h0, r[31:21]}, 0);
		rd(`PTR_CMD_PIN, 3, '{r[17:10], {pin_exp, r[20:18]}, 8'h0, 8'h0, 8'h0, 8'h0});
		rd(`PTR_CMD_IOUT, 3, '{r[28:21], {iout_exp, r[31:29]}, 8'h0, 8'h0, 8'h0, 8'h0});
		filt_mode = 1;
		repeat (128) win(4, 16'h0400, 16'h0400, 0);
		i_host.poll(`PTR_CMD_PIN, 3, 8'h00, bb, ll);
		chk("pin_filt", 1, {bb[1][2:0], bb[0]} inside {[11'h3f0:11'h410]});
		i_host.poll(`PTR_CMD_IOUT, 3, 8'h00, bb, ll);
		chk("iout_filt", 1, {bb[1][2:0], bb[0]} inside {[11'h3f0:11'h410]});
		ein();
		final_report();
	end
	// Watchdog at nearly three times the expected run of some 22,000 cycles
	initial begin
		#600us;
		failures++;
		final_report();
	end
endmodule
bind ptr_top ptr_top_properties i_props (.clk(clk), .reset_n(reset_n), .ac_cycle(ac_cycle),
	.cmd_valid(cmd_valid), .cmd_code(cmd_code), .byte_ack(byte_ack), .rsp_byte_q(rsp_byte_q),
	.rsp_valid(rsp_valid),
	.rsp_last_q(rsp_last_q), .rsp_busy_q(rsp_busy_q), .cmd_err_q(cmd_err_q),
	.ein_tick_q(ein_tick_q));
